// file: common/table_access_consts.vh
// constants for the program space table access block
`ifndef TABLE_ACCESS_CONSTS_VH
`define TABLE_ACCESS_CONSTS_VH
`define TA_PAGE_CFG_BIT   7
`define TA_OP_READ_LOW    2'h0
`define TA_OP_READ_HIGH   2'h1
`define TA_OP_WRITE_LOW   2'h2
`define TA_OP_WRITE_HIGH  2'h3
`define TA_WORD_STEP      16'h0002
`define TA_PAGE_RESET     8'h00
`define TA_DATA_RESET     16'h0000
`endif

// file: logic/program_space_table_access.v
// table read/write path between the core and program memory / data eeprom
//
// Notes on behaviour
// RL1: word-mode low read returns program bits 15..0 as the full data word.
// RL2: byte-mode low read puts upper byte if select is 1, else lower byte.
// RL3: word-mode high read returns bits 23..16 low, upper data byte always zero.
// RL4: byte-mode high read returns selected byte; phantom byte reads as zero.
// RL5: program addresses step by two per 24-bit word, two parallel spaces.
// RL6: only high operations move bits 23..16; low ones reach program and eeprom words.
// RL7: requester never issues high operations toward data eeprom.
// RL8: page comes from the table page register; bit 7 selects configuration space.
// RL9: configuration space accepts reads in implemented areas only; writes blocked.
// RL10: reads and writes both support byte and word sizes.
// RL11: byte select is the least significant bit of the effective address.
// RL12: reads of unimplemented configuration locations return zero with no error.
`timescale 1ns/1ns
`default_nettype none
`include "table_access_consts.vh"

module program_space_table_access #(
    parameter CFG_IMPL_LO = 16'h0000,
    parameter CFG_IMPL_HI = 16'h0007
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire        ce_i,
    input  wire        page_wr_i,
    input  wire [7:0]  page_wdata_i,
    input  wire        req_i,
    input  wire [1:0]  op_i,
    input  wire        byte_i,
    input  wire        eeprom_i,
    input  wire [15:0] ea_i,
    input  wire [15:0] wdata_i,
    input  wire [23:0] pm_rdata_i,
    input  wire [15:0] ee_rdata_i,
    output reg  [7:0]  page_o,
    output reg         mem_rd_o,
    output reg         mem_wr_o,
    output reg         mem_eeprom_o,
    output reg         mem_cfg_o,
    output reg  [22:0] mem_addr_o,
    output reg  [23:0] mem_wdata_o,
    output reg  [2:0]  mem_wbe_o,
    output reg         rvalid_o,
    output reg  [15:0] rdata_o,
    output reg         wr_blocked_o
);

////////////////////////////////////////////////////////////////////////////////
// combinational request decode

reg        is_read;
reg        is_high;
reg        in_cfg;
reg        cfg_impl;
reg        bsel;
reg        wr_ok;
reg [2:0]  wbe_nxt;
reg [23:0] wdata_nxt;

////////////////////////////////////////////////////////////////////////////////
// operation decode helpers

function op_reads;
    input [1:0] op;
    begin
        op_reads = (op == `TA_OP_READ_LOW) || (op == `TA_OP_READ_HIGH);
    end
endfunction

function op_high;
    input [1:0] op;
    begin
        op_high = (op == `TA_OP_READ_HIGH) || (op == `TA_OP_WRITE_HIGH);
    end
endfunction

function in_range;
    input [15:0] addr;
    input [15:0] lo;
    input [15:0] hi;
    begin
        in_range = (addr >= lo) && (addr <= hi);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// byte fan-out for byte writes

wire [23:0] byte_fan;

genvar lane;
generate
    for (lane = 0; lane < 3; lane = lane + 1) begin : g_fan
        // every lane carries the low data byte; the lane enables pick the live one
        assign byte_fan[8*lane +: 8] = wdata_i[7:0];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// word index: one index per 24-bit word, both halves share the range

wire [22:0] word_idx;

assign word_idx = {1'b0, page_o[6:0], ea_i[15:1]}; // RL5

always @* begin
    is_read  = op_reads(op_i);
    is_high  = op_high(op_i); // RL6
    in_cfg   = page_o[`TA_PAGE_CFG_BIT] & ~eeprom_i; // RL8
    cfg_impl = in_range(ea_i, CFG_IMPL_LO[15:0], CFG_IMPL_HI[15:0]);
    bsel     = ea_i[0]; // RL11
    wr_ok    = ~in_cfg & ~(eeprom_i & is_high); // RL9 RL7
    wbe_nxt  = 3'h0;
    wdata_nxt = 24'h000000;
    if (is_high) begin
        // phantom byte has no storage, so only bits 23..16 are written
        wdata_nxt = {byte_fan[23:16], 16'h0000};
        wbe_nxt   = (byte_i && bsel) ? 3'h0 : 3'h4; // RL10
    end else if (byte_i) begin
        wdata_nxt = {8'h00, byte_fan[15:0]};
        wbe_nxt   = bsel ? 3'h2 : 3'h1; // RL10 RL11
    end else begin
        wdata_nxt = {8'h00, wdata_i};
        wbe_nxt   = 3'h3; // RL10
    end
end

////////////////////////////////////////////////////////////////////////////////
// memory request stage

reg        pend_r;
reg        pend_high_r;
reg        pend_byte_r;
reg        pend_bsel_r;
reg        pend_zero_r;
reg        pend_ee_r;

always @(posedge clk_i) begin
    if (!nrst_i) begin
        page_o       <= `TA_PAGE_RESET;
        mem_rd_o     <= 1'b0;
        mem_wr_o     <= 1'b0;
        mem_eeprom_o <= 1'b0;
        mem_cfg_o    <= 1'b0;
        mem_addr_o   <= 23'h000000;
        mem_wdata_o  <= 24'h000000;
        mem_wbe_o    <= 3'h0;
        wr_blocked_o <= 1'b0;
        pend_r       <= 1'b0;
        pend_high_r  <= 1'b0;
        pend_byte_r  <= 1'b0;
        pend_bsel_r  <= 1'b0;
        pend_zero_r  <= 1'b0;
        pend_ee_r    <= 1'b0;
    end else if (ce_i) begin
        if (page_wr_i) begin
            page_o <= page_wdata_i; // RL8
        end
        mem_rd_o     <= req_i && is_read && !(in_cfg && !cfg_impl); // RL12
        mem_wr_o     <= req_i && !is_read && wr_ok && (wbe_nxt != 3'h0); // RL9
        wr_blocked_o <= req_i && !is_read && !wr_ok; // RL9
        if (req_i) begin
            mem_eeprom_o <= eeprom_i;
            mem_cfg_o    <= in_cfg;
            mem_addr_o   <= word_idx; // RL5
            mem_wdata_o  <= wdata_nxt;
            mem_wbe_o    <= wbe_nxt;
        end
        pend_r      <= req_i && is_read;
        pend_high_r <= is_high;
        pend_byte_r <= byte_i;
        pend_bsel_r <= bsel;
        pend_zero_r <= in_cfg && !cfg_impl; // RL12
        pend_ee_r   <= eeprom_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data formatting

reg [15:0] rd_word;
reg [15:0] rd_nxt;

always @* begin
    rd_word = pend_ee_r ? ee_rdata_i : pm_rdata_i[15:0];
    rd_nxt  = `TA_DATA_RESET;
    if (pend_zero_r) begin
        rd_nxt = `TA_DATA_RESET; // RL12
    end else if (pend_high_r) begin
        if (pend_byte_r && pend_bsel_r) begin
            rd_nxt = 16'h0000; // RL4
        end else begin
            rd_nxt = {8'h00, pm_rdata_i[23:16]}; // RL3 RL4
        end
    end else if (pend_byte_r) begin
        rd_nxt = {8'h00, pend_bsel_r ? rd_word[15:8] : rd_word[7:0]}; // RL2
    end else begin
        rd_nxt = rd_word; // RL1
    end
end

always @(posedge clk_i) begin
    if (!nrst_i) begin
        rvalid_o <= 1'b0;
        rdata_o  <= `TA_DATA_RESET;
    end else if (ce_i) begin
        rvalid_o <= pend_r;
        if (pend_r) begin
            rdata_o <= rd_nxt;
        end
    end
end

endmodule // program_space_table_access
`default_nettype wire

// file: verification/psta_chk.sv
// assertions on the table access block ports
`timescale 1ns/1ns
`default_nettype none
module psta_chk #(parameter CFG_IMPL_HI = 16'h0007) (
    input wire logic clk_i, nrst_i, ce_i, req_i, byte_i, eeprom_i, mem_rd_o, mem_wr_o, rvalid_o, wr_blocked_o,
    input wire logic [1:0] op_i, input wire logic [15:0] ea_i, rdata_o,
    input wire logic [7:0] page_o, input wire logic [22:0] mem_addr_o);
default clocking @(posedge clk_i); endclocking
default disable iff (!nrst_i);
wire go = req_i && ce_i && !eeprom_i;
sequence zero_rd; !mem_rd_o ##1 (rvalid_o && rdata_o == 0); endsequence
chk_user_rd: assert property (go && !op_i[1] && !page_o[7] |=> mem_rd_o ##1 rvalid_o) else $error("rd");
chk_cfg_wr: assert property (go && op_i[1] && page_o[7] |=> wr_blocked_o && !mem_wr_o) else $error("cw");
chk_ee_high: assert property (req_i && ce_i && eeprom_i && op_i == 3 |=> wr_blocked_o) else $error("eh");
chk_phantom_word: assert property (rvalid_o && $past(op_i, 2) == 1 |-> rdata_o[15:8] == 0) else $error("ph");
chk_addr_map: assert property (go && !page_o[7] |=> mem_addr_o[14:0] == $past(ea_i) >> 1) else $error("ad");
chk_wr_cause: assert property (mem_wr_o |-> $past(req_i) && $past(op_i) > 1) else $error("wc");
chk_cfg_zero: assert property (go && !op_i[1] && page_o[7] && ea_i > 2 * CFG_IMPL_HI + 1 |=> zero_rd) else $error("cz");
chk_byte_phantom: assert property (go && op_i == 1 && byte_i && ea_i[0] |=> ##1 rdata_o == 0) else $error("bp");
endmodule // psta_chk
`default_nettype wire

// file: verification/pm_model.sv
// program memory and eeprom model answering read strobes
`timescale 1ns/1ns
`default_nettype none
module pm_model (input wire logic clk_i, rd, input wire logic [22:0] addr,
    output var logic [23:0] pm, output var logic [15:0] ee);
logic [23:0] last = 0;
wire [23:0] word = {addr[7:0] ^ 8'h5a, addr[15:0] ^ 16'hc3a7};
// data stands while the strobe is high; released lines show the inverse of the last word
always @(posedge clk_i) if (rd) last <= word;
always @* pm = rd ? word : ~last;
always @* ee = pm[15:0];
endmodule // pm_model
`default_nettype wire

// file: verification/test_program_space_table_access.sv
// self-checking bench for the table access block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module test_program_space_table_access;
logic clk_i = 0, nrst_i = 0, ce_i = 1, page_wr_i = 0, req_i = 0, byte_i = 0, eeprom_i = 0;
logic [7:0] page_wdata_i = 0, page_o; logic [1:0] op_i = 0; logic [15:0] ea_i = 0, wdata_i = 0, ee, rdata_o;
logic [23:0] pm, mem_wdata_o, m; logic [22:0] mem_addr_o; logic [2:0] mem_wbe_o;
logic mem_rd_o, mem_wr_o, mem_eeprom_o, mem_cfg_o, rvalid_o, wr_blocked_o;
int n_fail = 0, n_tests = 0;
always #5 clk_i = ~clk_i;
program_space_table_access dut (.pm_rdata_i(pm), .ee_rdata_i(ee), .*);
pm_model mdl (.clk_i(clk_i), .rd(mem_rd_o), .addr(mem_addr_o), .pm(pm), .ee(ee));
function automatic logic [23:0] mw(logic [15:0] a); return {a[7:0] ^ 8'h5a, a ^ 16'hc3a7}; endfunction
task op(input [1:0] o, input b, e, input [15:0] a, d);
    op_i = o; byte_i = b; eeprom_i = e; ea_i = a; wdata_i = d; req_i = 1;
    @(negedge clk_i); req_i = 0;
endtask
task rd(input [1:0] o, input b, e, input [15:0] a, x);
    op(o, b, e, a, 0); @(negedge clk_i);
    `CHK({rvalid_o, rdata_o}, {1'b1, x})
endtask
task wr(input [1:0] o, input b, e, input [15:0] a, d, input [2:0] be, input [23:0] x);
    op(o, b, e, a, d);
    `CHK({mem_wr_o, wr_blocked_o, mem_wbe_o & {3{|be}}, mem_wdata_o & {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}}}, {|be, ~|be, be, x})
    @(negedge clk_i);
endtask
task setpg(input [7:0] p);
    page_wdata_i = p; page_wr_i = 1; @(negedge clk_i); page_wr_i = 0; `CHK(page_o, p)
endtask
task t_rd;
    setpg(8'h00); m = mw(16'h0092);
    rd(0, 0, 0, 16'h0124, m[15:0]);
    rd(0, 1, 0, 16'h0125, {8'h0, m[15:8]});
    rd(0, 1, 0, 16'h0124, {8'h0, m[7:0]});
    rd(1, 0, 0, 16'h0124, {8'h0, m[23:16]});
    rd(1, 1, 0, 16'h0124, {8'h0, m[23:16]});
    rd(1, 1, 0, 16'h0125, 16'h0);
    rd(0, 0, 1, 16'h0124, m[15:0]);
    m = mw(16'h0093); rd(1, 0, 0, 16'h0126, {8'h0, m[23:16]});
endtask
task t_cfg;
    setpg(8'h80); m = mw(16'h0002);
    rd(0, 0, 0, 16'h0004, m[15:0]);
    rd(0, 0, 0, 16'h0020, 16'h0);
    wr(2, 0, 0, 16'h0004, 16'h1234, 0, 0);
    setpg(8'h00);
endtask
task t_wr;
    wr(2, 0, 0, 16'h0010, 16'h1234, 3'h3, 24'h001234);
    wr(2, 1, 0, 16'h0011, 16'h00ab, 3'h2, 24'h00ab00);
    wr(3, 0, 0, 16'h0010, 16'h00cd, 3'h4, 24'hcd0000);
    wr(3, 0, 1, 16'h0010, 16'h00cd, 0, 0);
endtask
task stop_test;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
endtask
initial begin
    repeat (4) @(negedge clk_i);
    nrst_i = 1; `CHK({page_o, rvalid_o, mem_wr_o}, 0)
    t_rd; t_cfg; t_wr; stop_test;
end
initial begin #5000; n_fail++; stop_test; end
endmodule // test_program_space_table_access
bind program_space_table_access psta_chk #(.CFG_IMPL_HI(CFG_IMPL_HI)) u_chk (.*);
`default_nettype wire
